/* File: rtl/fpsq_map.svh */
// Purpose: Named constants of the square-root latency_setting
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only, no logic
`ifndef FPSQ_MAP_SVH
`define FPSQ_MAP_SVH

// Default operand format
`define FPSQ_EXP_W_DEF     8
`define FPSQ_MAN_W_DEF     23

// Latency derivation: long = man + pad, short = (man + pad) / 2 + add
`define FPSQ_LAT_PAD       5
`define FPSQ_LAT_SHORT_ADD 2

// Output buffer entries
`define FPSQ_BUF_DEPTH     2

// Flag bit positions above the result in the buffered word
`define FPSQ_FLG_INV       0
`define FPSQ_FLG_ZERO      1
`define FPSQ_FLG_OVF       2
`define FPSQ_FLG_W         3

`endif

/* File: rtl/fpsq_pkg.sv */
// Purpose: Types shared by the square-root latency_setting files
// Assumes: Nothing is imported; users write fpsq_pkg::name
// Notes:   Constants live in fpsq_map.svh
package fpsq_pkg;

  // Operand class decided in the first stage
  typedef enum logic [1:0] {
    FPSQ_K_NORM = 2'h0,
    FPSQ_K_ZERO = 2'h1,
    FPSQ_K_INF  = 2'h3,
    FPSQ_K_INV  = 2'h2
  } fpsq_kind_t;

  // Latency setting choice
  typedef enum logic {
    FPSQ_LAT_LONG  = 1'h0,
    FPSQ_LAT_SHORT = 1'h1
  } fpsq_lat_t;

endpackage

/* File: rtl/fpsq_stream_if.sv */
// Purpose: Valid/ready word carrier between latency_setting and buffer
// Assumes: Source and sink share one clock
// Notes:   Data is meaningful only while valid is high
`timescale 1ns/1ps
interface fpsq_stream_if #(
  parameter int W = 32
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/fpsq_pair_buf.sv */
// Purpose: Small FIFO holding finished results for the user side
// Assumes: DEPTH is a power of two; i_en freezes both ends
// Notes:   Ready is plain not-full, so the filling side sees stalls
`timescale 1ns/1ps
module fpsq_pair_buf #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic   i_sys_clk, // System clock
  input  wire logic   i_arst_n,  // Async reset, active low
  input  wire logic   i_en,      // Clock enable for push and pop
  fpsq_stream_if.snk  wr,        // Filling side
  fpsq_stream_if.src  rd         // Draining side
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [CW-1:0] cnt_ff;
  logic          push;
  logic          pop;

  // Handshakes; nothing moves while the enable is low
  assign wr.ready = (cnt_ff != CW'(DEPTH));
  assign rd.valid = (cnt_ff != '0);
  assign rd.data  = mem_ff[rd_ff];
  assign push     = i_en & wr.valid & wr.ready;
  assign pop      = i_en & rd.valid & rd.ready;

  // Storage written only on an accepted push
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= wr.data;
    end
  end

  // Pointers wrap naturally at a power-of-two depth
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end

  // Occupancy; push and pop together leave it unchanged
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= '0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + 1'b1;
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule

/* File: rtl/fpsq_sqrt.sv */
// Purpose: Fully pipelined floating-point square root
// Assumes: Operand and result packed sign, exponent, mantissa
// Notes:   Digit-by-digit root spread over the middle stages
//
// Overview of operation
// - Fixed latency: mantissa plus five, or shorter
// - Round to nearest only
// - Clock enable low freezes everything
// - Clear resets whole latency_setting asynchronously except buffer storage
// - Sign MSB, exponent next, mantissa LSBs
// - Overflow when result exponent all ones, unless invalid
// - Zero flag when result equals zero
// - Negative nonzero normal or NaN operand: invalid, all ones
// - Zero/denormal give zero; positive normal normal
// - +Inf gives Inf; -Inf gives invalid
// - Bias is two to (exp-1) minus one
// - Single 16/28, double 30/57 clocks
`timescale 1ns/1ps
`include "fpsq_map.svh"
module fpsq_sqrt #(
  parameter int                  EXP_W   = `FPSQ_EXP_W_DEF,
  parameter int                  MAN_W   = `FPSQ_MAN_W_DEF,
  parameter fpsq_pkg::fpsq_lat_t LAT_SEL = fpsq_pkg::FPSQ_LAT_LONG
) (
  input  wire logic                     i_sys_clk,   // 50 MHz clock
  input  wire logic                     i_arst_n,    // Clear, active low
  input  wire logic                     i_clk_en,    // Stall when low
  input  wire logic                     i_in_valid,  // Operand present
  output logic                          o_in_ready,  // Operand taken
  input  wire logic [EXP_W+MAN_W:0]     i_operand,   // Packed operand
  output logic                          o_out_valid, // Result present
  input  wire logic                     i_out_ready, // User takes result
  output logic [EXP_W+MAN_W:0]          o_result,    // Packed root
  output logic                          o_overflow,  // Exponent all ones
  output logic                          o_zero,      // Result is zero
  output logic                          o_invalid    // Invalid operation
);
  // Format and timing derived from the widths
  localparam int W    = 1 + EXP_W + MAN_W;
  localparam int R    = MAN_W + 2;         // Root bits incl. round bit
  localparam int LAT  = (LAT_SEL == fpsq_pkg::FPSQ_LAT_LONG) ?
                        MAN_W + `FPSQ_LAT_PAD :
                        (MAN_W + `FPSQ_LAT_PAD) / 2 + `FPSQ_LAT_SHORT_ADD;
  localparam int NC   = LAT - 2;           // Iteration stages
  localparam int K    = (R + NC - 1) / NC; // Iterations per stage
  localparam int RMW  = R + 2;             // Partial remainder width
  localparam int SW   = RMW + R + 2 * R;   // Iteration state width
  localparam int BIAS = 2 ** (EXP_W - 1) - 1;
  localparam int DW   = W + `FPSQ_FLG_W;

  // One group of root iterations; base skips the ones beyond R
  function automatic logic [SW-1:0] sq_step(input logic [SW-1:0] s,
                                            input int base);
    logic [RMW-1:0] rem;
    logic [R-1:0]   root;
    logic [2*R-1:0] x;
    logic [RMW-1:0] trial;
    {rem, root, x} = s;
    trial = '0;
    for (int k = 0; k < K; k++) begin
      if (base + k < R) begin
        rem   = {rem[RMW-3:0], x[2*R-1 -: 2]};
        x     = {x[2*R-3:0], 2'h0};
        trial = {root, 2'h1};
        if (rem >= trial) begin
          rem  = rem - trial;
          root = {root[R-2:0], 1'h1};
        end else begin
          root = {root[R-2:0], 1'h0};
        end
      end
    end
    return {rem, root, x};
  endfunction

  // Field split of the incoming word
  logic                 op_sgn;
  logic [EXP_W-1:0]     op_exp;
  logic [MAN_W-1:0]     op_man;
  logic [EXP_W:0]       exp_sum;
  logic [R-1:0]         rad;
  fpsq_pkg::fpsq_kind_t op_kind;

  assign op_sgn  = i_operand[W-1];
  assign op_exp  = i_operand[W-2 -: EXP_W];
  assign op_man  = i_operand[MAN_W-1:0];
  // Halved unbiased exponent re-biased: (e + bias) / 2
  assign exp_sum = {1'b0, op_exp} + (EXP_W+1)'(BIAS);
  // Even biased exponent means odd true exponent: double the radicand
  assign rad     = op_exp[0] ? {2'h1, op_man} : {1'h1, op_man, 1'h0};

  // Classification of special operands
  always_comb begin
    if (op_exp == '0) begin
      op_kind = fpsq_pkg::FPSQ_K_ZERO;
    end else if (&op_exp) begin
      if (op_man != '0 || op_sgn) begin
        op_kind = fpsq_pkg::FPSQ_K_INV;
      end else begin
        op_kind = fpsq_pkg::FPSQ_K_INF;
      end
    end else if (op_sgn) begin
      op_kind = fpsq_pkg::FPSQ_K_INV;
    end else begin
      op_kind = fpsq_pkg::FPSQ_K_NORM;
    end
  end

  // Latency_setting state, index 0 is the unpack stage
  logic                 vld_ff  [NC+1];
  fpsq_pkg::fpsq_kind_t kind_ff [NC+1];
  logic [EXP_W-1:0]     exp_ff  [NC+1];
  logic [SW-1:0]        st_ff   [NC+1];
  logic                 adv;
  logic                 buf_ready;

  // Advance on enable unless a finished word cannot be stored
  assign adv        = i_clk_en & (buf_ready | ~vld_ff[NC]);
  assign o_in_ready = adv;

  // Unpack stage
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vld_ff[0]  <= 1'b0;
      kind_ff[0] <= fpsq_pkg::FPSQ_K_ZERO;
      exp_ff[0]  <= '0;
      st_ff[0]   <= '0;
    end else if (adv) begin
      vld_ff[0]  <= i_in_valid;
      kind_ff[0] <= op_kind;
      exp_ff[0]  <= exp_sum[EXP_W:1];
      st_ff[0]   <= {{RMW{1'b0}}, {R{1'b0}}, rad, {R{1'b0}}};
    end
  end

  // Iteration stages; each word travels alone, so results never mix
  for (genvar j = 1; j <= NC; j++) begin : g_stage
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        vld_ff[j]  <= 1'b0;
        kind_ff[j] <= fpsq_pkg::FPSQ_K_ZERO;
        exp_ff[j]  <= '0;
        st_ff[j]   <= '0;
      end else if (adv) begin
        vld_ff[j]  <= vld_ff[j-1];
        kind_ff[j] <= kind_ff[j-1];
        exp_ff[j]  <= exp_ff[j-1];
        st_ff[j]   <= sq_step(st_ff[j-1], K * (j - 1));
      end
    end
  end

  // Rounding of the finished root
  logic [RMW-1:0]   fin_rem;
  logic [R-1:0]     fin_root;
  logic [2*R-1:0]   fin_x;
  logic             rnd_up;
  logic [MAN_W:0]   man_rnd;
  logic [EXP_W-1:0] exp_rnd;
  logic [W-1:0]     res;
  logic             res_ovf;
  logic [DW-1:0]    res_word;

  assign {fin_rem, fin_root, fin_x} = st_ff[NC];
  // Nearest, ties to even; an exact tie cannot occur with zero remainder
  assign rnd_up  = fin_root[0] & ((fin_rem != '0) | fin_root[1]);
  assign man_rnd = {1'b0, fin_root[R-2:1]} + (MAN_W+1)'(rnd_up);
  // Carry out of the mantissa means the root rounded up to 2.0
  assign exp_rnd = exp_ff[NC] + EXP_W'(man_rnd[MAN_W]);

  // Result selection by operand class
  always_comb begin
    unique case (kind_ff[NC])
      fpsq_pkg::FPSQ_K_NORM: res = {1'b0, exp_rnd, man_rnd[MAN_W-1:0]};
      fpsq_pkg::FPSQ_K_ZERO: res = '0;
      fpsq_pkg::FPSQ_K_INF:  res = {1'b0, {EXP_W{1'b1}},
                                    {MAN_W{1'b0}}};
      fpsq_pkg::FPSQ_K_INV:  res = '1;
    endcase
  end

  // Flags judged on the value actually delivered
  assign res_ovf  = (kind_ff[NC] != fpsq_pkg::FPSQ_K_INV) &
                    (&res[W-2 -: EXP_W]);
  always_comb begin
    res_word = {{`FPSQ_FLG_W{1'b0}}, res};
    res_word[W+`FPSQ_FLG_OVF]  = res_ovf;
    res_word[W+`FPSQ_FLG_ZERO] = (res == '0);
    res_word[W+`FPSQ_FLG_INV]  = (kind_ff[NC] ==
                                  fpsq_pkg::FPSQ_K_INV);
  end

  // Output buffer: absorbs a stalled user without losing a result
  fpsq_stream_if #(.W(DW)) fill_if ();
  fpsq_stream_if #(.W(DW)) drain_if ();

  assign fill_if.valid  = vld_ff[NC];
  assign fill_if.data   = res_word;
  assign buf_ready      = fill_if.ready;
  assign drain_if.ready = i_out_ready;

  fpsq_pair_buf #(
    .W     (DW),
    .DEPTH (`FPSQ_BUF_DEPTH)
  ) u_out_buf (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_en      (i_clk_en),
    .wr        (fill_if),
    .rd        (drain_if)
  );

  // Outputs straight from buffer storage; valid masks warm-up words
  assign o_out_valid = drain_if.valid;
  assign o_result    = drain_if.data[W-1:0];
  assign o_overflow  = drain_if.data[W+`FPSQ_FLG_OVF];
  assign o_zero      = drain_if.data[W+`FPSQ_FLG_ZERO];
  assign o_invalid   = drain_if.data[W+`FPSQ_FLG_INV];
endmodule

/* File: test/fpsq_checker.sv */
// Purpose: Port-level checks of the root latency_setting
// Assumes: Sees only the top module's ports
// Notes:   Latency is tracked only from an operand taken while idle
`timescale 1ns/1ps
module fpsq_checker #(
  parameter int                  EXP_W   = 8,
  parameter int                  MAN_W   = 23,
  parameter fpsq_pkg::fpsq_lat_t LAT_SEL = fpsq_pkg::FPSQ_LAT_LONG
) (
  input wire logic                 i_sys_clk,   // Clock
  input wire logic                 i_arst_n,    // Clear, active low
  input wire logic                 i_clk_en,    // Enable
  input wire logic                 i_in_valid,  // Operand offered
  input wire logic                 o_in_ready,  // Operand taken
  input wire logic [EXP_W+MAN_W:0] i_operand,   // Operand
  input wire logic                 o_out_valid, // Result present
  input wire logic                 i_out_ready, // Result taken
  input wire logic [EXP_W+MAN_W:0] o_result,    // Root
  input wire logic                 o_overflow,  // Overflow flag
  input wire logic                 o_zero,      // Zero flag
  input wire logic                 o_invalid    // Invalid flag
);
  localparam int W   = EXP_W + MAN_W;
  localparam int LAT = (LAT_SEL == fpsq_pkg::FPSQ_LAT_LONG) ?
                       MAN_W + 5 : (MAN_W + 5) / 2 + 2;
  logic [7:0] idle_ff; // Enabled edges since last take, saturating
  logic [7:0] trk_ff;  // Enabled edges since an idle take
  logic       quiet;
  // A word leaves the latency_setting LAT-1 edges after its take
  assign quiet = (idle_ff >= 8'(LAT)) && !o_out_valid;
  // Idle means nothing in flight and nothing buffered
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) idle_ff <= 8'(LAT + 1);
    else if (i_in_valid && o_in_ready) idle_ff <= 8'h00;
    else if (i_clk_en && idle_ff <= 8'(LAT)) idle_ff <= idle_ff + 8'h01;
  end
  // Only an isolated operand has an unambiguous arrival edge
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) trk_ff <= 8'h00;
    else if (i_in_valid && o_in_ready && quiet) trk_ff <= 8'h01;
    else if (trk_ff != 8'h00 && i_clk_en)
      trk_ff <= (trk_ff == 8'(LAT + 1)) ? 8'h00 : trk_ff + 8'h01;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  a_stall_frozen: assert property (!i_clk_en && o_out_valid |=>
    o_out_valid && $stable(o_result) &&
    $stable({o_overflow, o_zero, o_invalid}))
    else $error("result moved while stalled");
  a_ready_gated: assert property (!i_clk_en |-> !o_in_ready)
    else $error("operand taken while stalled");
  a_zero_flag: assert property (o_out_valid |-> o_zero == !(|o_result))
    else $error("zero flag disagrees with result");
  a_invalid_ones: assert property (o_out_valid && o_invalid |-> &o_result)
    else $error("invalid result not all ones");
  a_ovf_exp_ones: assert property (o_out_valid |->
    o_overflow == (&o_result[W-1:MAN_W] && !o_invalid))
    else $error("overflow flag disagrees with exponent");
  a_one_flag: assert property (o_out_valid |->
    $onehot0({o_overflow, o_zero, o_invalid}))
    else $error("more than one flag raised");
  a_sign_pos: assert property (o_out_valid && !o_invalid |-> !o_result[W])
    else $error("valid root is negative");
  a_lat_early: assert property (trk_ff != 8'h00 && trk_ff < 8'(LAT)
    |-> !o_out_valid) else $error("result before latency");
  a_lat_due: assert property (trk_ff == 8'(LAT) |-> o_out_valid)
    else $error("result late");
endmodule
bind fpsq_sqrt fpsq_checker #(.EXP_W(EXP_W), .MAN_W(MAN_W),
  .LAT_SEL(LAT_SEL)) u_chk (.i_sys_clk, .i_arst_n, .i_clk_en,
  .i_in_valid, .o_in_ready, .i_operand, .o_out_valid, .i_out_ready,
  .o_result, .o_overflow, .o_zero, .o_invalid);

/* File: test/fpsq_user_sink.sv */
// Purpose: User logic that drains results
// Assumes: Ready moves on falling edges
// Notes:   Stalls on request so the buffer can fill
`timescale 1ns/1ps
module fpsq_user_sink #(
  parameter int W = 32
) (
  input  wire logic         i_sys_clk, // Clock
  input  wire logic         i_arst_n,  // Reset, active low
  input  wire logic         i_clk_en,  // Pop enable
  input  wire logic         i_hold,    // Stall the drain
  input  wire logic         i_valid,   // Result present
  input  wire logic [W+2:0] i_word,    // Flags and result
  output logic              o_ready    // Taking results
);
  logic [W+2:0] got_q[$];
  initial o_ready = 1'b0;
  // Ready changes away from the sampling edge
  always @(negedge i_sys_clk) o_ready <= !i_hold;
  // Outputs are only taken while flagged valid
  always @(posedge i_sys_clk) begin
    if (i_arst_n && i_valid && o_ready && i_clk_en) got_q.push_back(i_word);
  end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench of the root latency_setting
// Assumes: Single format, both latency settings side by side
// Notes:   Results are judged from what the user sink collected
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin \
  n_fail++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
  localparam int LAT   = 28; // Long setting, 23-bit mantissa
  localparam int LAT_S = 16; // Short setting, 23-bit mantissa
  logic        clk = 0, arst_n = 0, en = 1, vin = 0, hold = 0;
  logic        in_ready, out_valid, out_ready, ovf, zero, inv;
  logic [31:0] operand = 32'h0, result;
  int          n_fail = 0, total_checks = 0, n_ref = 0;
  logic        s_valid, s_ready, s_ovf, s_zero, s_inv;
  logic [31:0] s_result;
  logic [31:0] ops[14] = '{32'h40800000, 32'h3F800000, 32'h40000000,
    32'h2D0B496A, 32'h7F7FFFFF, 32'h00000000, 32'h80000000, 32'h00000001,
    32'h80400000, 32'h7F800000, 32'hFF800000, 32'h7FC00000, 32'hFFC00000,
    32'hBF800000};
  logic [34:0] exps[14] = '{35'h0_40000000, 35'h0_3F800000,
    35'h0_3FB504F3, 35'h0_363CD4EB, 35'h0_5F7FFFFF, 35'h2_00000000,
    35'h2_00000000, 35'h2_00000000, 35'h2_00000000, 35'h1_7F800000,
    35'h4_FFFFFFFF, 35'h4_FFFFFFFF, 35'h4_FFFFFFFF, 35'h4_FFFFFFFF};
  // Default widths stand for single precision
  fpsq_sqrt #(.LAT_SEL(fpsq_pkg::FPSQ_LAT_LONG)) u_dut (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_clk_en(en), .i_in_valid(vin),
    .o_in_ready(in_ready), .i_operand(operand), .o_out_valid(out_valid),
    .i_out_ready(out_ready), .o_result(result), .o_overflow(ovf),
    .o_zero(zero), .o_invalid(inv));
  fpsq_user_sink #(.W(32)) u_sink (.i_sys_clk(clk), .i_arst_n(arst_n),
    .i_clk_en(en), .i_hold(hold), .i_valid(out_valid),
    .i_word({inv, zero, ovf, result}), .o_ready(out_ready));
  // Short setting takes exactly what the long one takes
  fpsq_sqrt #(.LAT_SEL(fpsq_pkg::FPSQ_LAT_SHORT)) u_dut_s (
    .i_sys_clk(clk), .i_arst_n(arst_n), .i_clk_en(en),
    .i_in_valid(vin & in_ready), .o_in_ready(), .i_operand(operand),
    .o_out_valid(s_valid), .i_out_ready(s_ready), .o_result(s_result),
    .o_overflow(s_ovf), .o_zero(s_zero), .o_invalid(s_inv));
  fpsq_user_sink #(.W(32)) u_sink_s (.i_sys_clk(clk), .i_arst_n(arst_n),
    .i_clk_en(en), .i_hold(1'b0), .i_valid(s_valid),
    .i_word({s_inv, s_zero, s_ovf, s_result}), .o_ready(s_ready));
  initial forever #10 clk = ~clk;
  // Offer until taken; a long refusal briefly stalls, then frees the sink
  task send(input logic [31:0] op);
    int k;
    k = 0;
    @(negedge clk);
    vin = 1;
    operand = op;
    forever begin
      en = !(k == 2 || k == 3);
      if (k == 4) hold = 0;
      #1;
      if (in_ready === 1'b1) break;
      n_ref++;
      @(negedge clk);
      k++;
    end
    @(posedge clk);
  endtask
  task idle;
    @(negedge clk);
    vin = 0;
  endtask
  task drain(input int n);
    for (int k = 0; k < 300 && u_sink.got_q.size() < n; k++) @(posedge clk);
    `CHK("count", n, u_sink.got_q.size())
  endtask
  // Every operand class back to back
  task t_truth;
    u_sink.got_q.delete();
    foreach (ops[i]) send(ops[i]);
    idle;
    drain(14);
    `CHK("count_s", 14, u_sink_s.got_q.size())
    foreach (exps[i]) begin
      `CHK("root", exps[i], u_sink.got_q[i])
      `CHK("root_s", exps[i], u_sink_s.got_q[i])
    end
  endtask
  // Edges from take to result, with an optional stall in flight
  task t_lat(input int stall);
    int n;
    int ns;
    u_sink.got_q.delete();
    send(32'h41100000);
    n = 0;
    ns = -1;
    @(negedge clk);
    vin = 0;
    while (out_valid !== 1'b1 && n < 200) begin
      // Short result stands one cycle only, as its sink drains at once
      if (s_valid === 1'b1 && ns < 0) ns = n;
      en = (n < 3 || n >= 3 + stall);
      @(negedge clk);
      n++;
    end
    en = 1;
    // Edges counted from the taking edge: one short of the latency
    `CHK("latency", LAT - 1 + stall, n)
    `CHK("latency_s", LAT_S - 1 + stall, ns)
    drain(1);
    `CHK("root", 35'h0_40400000, u_sink.got_q[0])
  endtask
  // Sink stalls until operands are refused; nothing may be lost
  task t_fill;
    u_sink.got_q.delete();
    u_sink_s.got_q.delete();
    hold = 1;
    n_ref = 0;
    for (int n = 0; n < 36; n++) send({1'b0, 8'(27 + 2 * n), 23'h0});
    idle;
    `CHK("refused", 1'b1, n_ref > 0)
    drain(36);
    `CHK("count_s", 36, u_sink_s.got_q.size())
    for (int n = 0; n < 36; n++) begin
      `CHK("order", {3'h0, 1'b0, 8'(77 + n), 23'h0}, u_sink.got_q[n])
      `CHK("order_s", {3'h0, 1'b0, 8'(77 + n), 23'h0}, u_sink_s.got_q[n])
    end
  endtask
  // Clear between edges empties everything at once
  task t_reset;
    u_sink.got_q.delete();
    hold = 1;
    for (int n = 0; n < 3; n++) send(32'h40800000);
    idle;
    repeat (LAT + 2) @(posedge clk);
    `CHK("filled", 1'b1, out_valid)
    @(negedge clk);
    arst_n = 0;
    #1 `CHK("cleared", 1'b0, out_valid)
    repeat (2) @(negedge clk);
    arst_n = 1;
    hold = 0;
    repeat (LAT + 5) @(posedge clk);
    `CHK("stale", 0, u_sink.got_q.size())
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #120000;
    n_fail++;
    $display("mismatch watchdog exp done got hang");
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clk);
    `CHK("reset_valid", 1'b0, out_valid)
    @(negedge clk);
    arst_n = 1;
    t_truth;
    t_lat(0);
    t_lat(5);
    t_fill;
    t_reset;
    wrap_up;
  end
endmodule
